// >>> logic/cpl_top.sv
// Control pin logic of a single-cell switch-mode charger, with an AHB-Lite register slave.
// Assumes power stage status and a limit converter on REF_CLK; pins from outside are synchronised here.
//
// How it works
// - Alert pin pulses low for 256 us.
// - Boost only when config bit and request high.
// - Charge only when config bit and allow low.
// - Effective limit is smaller of pin and field.
// - Pin limit disabled uses only the field.
// - Thermistor out of window suspends charging.
// - One second press leaves ship mode.
// - Long press without supply cycles battery switch.
// - Status pin low charging, blinks on fault.
`timescale 1ns/100ps
module cpl_top #(
  parameter int unsigned SHIP_EXIT_CNT = cpl_pkg::SHIP_EXIT_CYC,
  parameter int unsigned LONG_PRESS_CNT = cpl_pkg::LONG_PRESS_CYC,
  parameter int unsigned SWITCH_OFF_CNT = cpl_pkg::SWITCH_OFF_CYC,
  parameter int unsigned BLINK_HALF_CNT = cpl_pkg::BLINK_HALF_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // Host control pins (asynchronous)
  input wire logic BOOST_REQUEST,
  input wire logic CHARGE_ALLOW_N,
  input wire logic WAKE_BUTTON_N,
  // Analog front end flags (asynchronous)
  input wire logic THERM_OUT_OF_RANGE,
  input wire logic SUPPLY_PRESENT,
  // Power stage status (same clock)
  input wire logic CHARGE_DONE,
  input wire logic STAGE_FAULT,
  input wire logic [cpl_pkg::LIMIT_W-1:0] RESISTOR_LIMIT_PIN,
  // Open-drain outputs
  output cpl_pkg::cpl_od_s ALERT_PIN,
  output cpl_pkg::cpl_od_s STATUS_PIN,
  // Power stage controls
  output logic BOOST_EN,
  output logic CHARGE_EN,
  output logic BATTERY_SWITCH_ON,
  output logic [cpl_pkg::LIMIT_W-1:0] INPUT_LIMIT,
  // Interrupt
  output logic IRQ
);
  import cpl_pkg::*;

  localparam int unsigned SYN_W = 5;

  // Two-flop synchronisers for every asynchronous pin
  logic [SYN_W-1:0] syn_a_r; // First stage, read only by the second
  logic [SYN_W-1:0] syn_b_r; // Second stage, safe to use
  wire [SYN_W-1:0] async_in = {SUPPLY_PRESENT, THERM_OUT_OF_RANGE, WAKE_BUTTON_N, CHARGE_ALLOW_N, BOOST_REQUEST};

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      syn_a_r <= 5'h06; // Active-low pins idle high, thermistor flag idles low
      syn_b_r <= 5'h06;
    end else begin
      syn_a_r <= async_in;
      syn_b_r <= syn_a_r;
    end
  end

  wire boost_req_s = syn_b_r[0];
  wire charge_allow_n_s = syn_b_r[1];
  wire wake_n_s = syn_b_r[2];
  wire therm_oor_s = syn_b_r[3];
  wire supply_s = syn_b_r[4];

  // Registers
  cpl_ctrl_s ctrl_r; // Software control word
  logic [EV_W-1:0] irq_stat_r; // Sticky events
  logic [EV_W-1:0] irq_mask_r; // Enable per event
  logic ship_mode_r; // Battery switch held off for shipping
  logic reset_off_r; // Battery switch off during system reset cycle

  // AHB-Lite address phase capture
  logic wr_pend_r; // Write data phase pending
  logic [7:0] wr_addr_r; // Latched write offset
  wire ahb_go = HSEL & HTRANS[1] & HREADY;
  wire ahb_wr = wr_pend_r;
  wire wr_ctrl = ahb_wr & (wr_addr_r == CTRL_OFS);
  wire wr_stat = ahb_wr & (wr_addr_r == IRQ_STAT_OFS);
  wire wr_mask = ahb_wr & (wr_addr_r == IRQ_MASK_OFS);

  // Derived control decisions
  wire boost_nxt = ctrl_r.boost_config_bit & boost_req_s;
  // Charge also needs the allow pin at a defined level, which the board guarantees
  wire charge_nxt = ctrl_r.charge_config_bit & ~charge_allow_n_s & ~therm_oor_s;
  wire pin_smaller = RESISTOR_LIMIT_PIN < ctrl_r.input_limit_field;
  wire [LIMIT_W-1:0] limit_nxt = (ctrl_r.pin_limit_enable & pin_smaller) ?
                                 RESISTOR_LIMIT_PIN : ctrl_r.input_limit_field;
  wire any_fault = STAGE_FAULT | therm_oor_s;

  // Read mux for the address phase, registered into the data phase
  wire [31:0] state_word = {18'h0, INPUT_LIMIT, 2'h0, any_fault, reset_off_r, ship_mode_r,
                            BATTERY_SWITCH_ON, CHARGE_EN, BOOST_EN};
  wire [31:0] rd_mux = (HADDR[7:0] == CTRL_OFS) ? 32'(ctrl_r) :
                       (HADDR[7:0] == STATE_OFS) ? state_word :
                       (HADDR[7:0] == IRQ_STAT_OFS) ? {26'h0, irq_stat_r} :
                       (HADDR[7:0] == IRQ_MASK_OFS) ? {26'h0, irq_mask_r} : 32'h0;

  // Bus slave: zero wait state, always OKAY, unmapped reads give zero
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA <= 32'h0;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_r <= ahb_go & HWRITE;
      wr_addr_r <= HADDR[7:0];
      if (ahb_go & ~HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  // Control and mask registers; ship entry bit is a one-cycle command
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ctrl_r <= cpl_ctrl_s'(CTRL_RST[13:0]);
      irq_mask_r <= IRQ_MASK_RST;
    end else begin
      ctrl_r.ship_enter <= 1'b0;
      if (wr_ctrl) begin
        ctrl_r <= cpl_ctrl_s'(HWDATA[13:0]);
      end
      ctrl_r.spare_bits <= 3'h0; // Unused gap always reads zero
      if (wr_mask) begin
        irq_mask_r <= HWDATA[EV_W-1:0];
      end
    end
  end

  // Power stage outputs, registered
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      BOOST_EN <= 1'b0;
      CHARGE_EN <= 1'b0;
      INPUT_LIMIT <= CTRL_RST[13:8];
    end else begin
      BOOST_EN <= boost_nxt;
      CHARGE_EN <= charge_nxt;
      INPUT_LIMIT <= limit_nxt;
    end
  end

  // Wake button hold timer; saturates so each press acts once
  logic [CNT_W-1:0] hold_cnt_r;
  wire [CNT_W-1:0] hold_inc = hold_cnt_r + 28'h1;
  wire hold_sat = (hold_cnt_r == CNT_W'(LONG_PRESS_CNT));
  wire ship_exit_hit = ~wake_n_s & (hold_inc == CNT_W'(SHIP_EXIT_CNT)) & ship_mode_r;
  wire long_press_hit = ~wake_n_s & (hold_inc == CNT_W'(LONG_PRESS_CNT)) & ~supply_s & ~ship_mode_r;

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      hold_cnt_r <= '0;
    end else if (wake_n_s) begin
      hold_cnt_r <= '0;
    end else if (!hold_sat) begin
      hold_cnt_r <= hold_inc;
    end
  end

  // Battery switch sequencing: ship mode and the system reset off interval
  logic [CNT_W-1:0] off_cnt_r;
  wire off_done = (off_cnt_r == CNT_W'(SWITCH_OFF_CNT - 1));

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      ship_mode_r <= 1'b0;
      reset_off_r <= 1'b0;
      off_cnt_r <= '0;
    end else begin
      if (ship_exit_hit) begin
        ship_mode_r <= 1'b0;
      end else if (ctrl_r.ship_enter) begin
        ship_mode_r <= 1'b1;
      end
      if (long_press_hit) begin
        reset_off_r <= 1'b1;
        off_cnt_r <= '0;
      end else if (reset_off_r) begin
        off_cnt_r <= off_cnt_r + 28'h1;
        if (off_done) begin
          reset_off_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      BATTERY_SWITCH_ON <= 1'b1;
    end else begin
      BATTERY_SWITCH_ON <= ~ship_mode_r & ~reset_off_r;
    end
  end

  // Event detection on registered state
  logic charge_q_r;
  logic boost_q_r;
  logic therm_q_r;
  logic fault_q_r;
  logic done_q_r;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      charge_q_r <= 1'b0;
      boost_q_r <= 1'b0;
      therm_q_r <= 1'b0;
      fault_q_r <= 1'b0;
      done_q_r <= 1'b0;
    end else begin
      charge_q_r <= CHARGE_EN;
      boost_q_r <= BOOST_EN;
      therm_q_r <= therm_oor_s;
      fault_q_r <= STAGE_FAULT;
      done_q_r <= CHARGE_DONE;
    end
  end

  wire [EV_W-1:0] ev_now;
  assign ev_now[EV_CHARGE] = charge_q_r ^ CHARGE_EN;
  assign ev_now[EV_BOOST] = boost_q_r ^ BOOST_EN;
  assign ev_now[EV_THERM] = therm_oor_s & ~therm_q_r;
  assign ev_now[EV_FAULT] = STAGE_FAULT & ~fault_q_r;
  assign ev_now[EV_DONE] = CHARGE_DONE & ~done_q_r;
  assign ev_now[EV_WAKE] = ship_exit_hit | long_press_hit;

  // Sticky status, write one to clear; a new event beats the clear
  wire [EV_W-1:0] w1c = wr_stat ? HWDATA[EV_W-1:0] : '0;
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_r <= '0;
      IRQ <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | ev_now;
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Alert pulse timer; events during a pulse merge into it
  logic [11:0] alert_cnt_r;
  wire alert_busy = (alert_cnt_r != 12'h0);
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      alert_cnt_r <= 12'h0;
      ALERT_PIN <= '{level: 1'b1, oe_n: 1'b1};
    end else begin
      if (!alert_busy && (|ev_now)) begin
        alert_cnt_r <= 12'(ALERT_PULSE_CYC);
      end else if (alert_busy) begin
        alert_cnt_r <= alert_cnt_r - 12'h1;
      end
      ALERT_PIN.level <= 1'b0;
      ALERT_PIN.oe_n <= ~((!alert_busy && (|ev_now)) || (alert_cnt_r > 12'h1));
    end
  end

  // Blink divider: one-cycle enable each half period of 1 Hz
  logic [CNT_W-1:0] blink_cnt_r;
  logic blink_r;
  wire blink_tick = (blink_cnt_r == CNT_W'(BLINK_HALF_CNT - 1));
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else begin
      blink_cnt_r <= blink_tick ? '0 : blink_cnt_r + 28'h1;
      if (blink_tick) begin
        blink_r <= ~blink_r;
      end
    end
  end

  // Status pin: released when disabled, blinks on fault, low while charging
  wire stat_drive = ~ctrl_r.status_pin_disable &
                    (any_fault ? blink_r : (CHARGE_EN & ~CHARGE_DONE));
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      STATUS_PIN <= '{level: 1'b1, oe_n: 1'b1};
    end else begin
      STATUS_PIN.level <= 1'b0;
      STATUS_PIN.oe_n <= ~stat_drive;
    end
  end
endmodule

// >>> include/cpl_pkg.sv
// Constants, register map and field layouts of the charger control pin logic.
// Assumes a 10 MHz reference clock and a single AHB-Lite master.
package cpl_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 10_000_000;
  // Printed times, in their own units
  localparam int unsigned ALERT_PULSE_US = 256;
  localparam int unsigned SHIP_EXIT_HOLD_MS = 1000;
  localparam int unsigned LONG_PRESS_HOLD_MS = 15000;
  localparam int unsigned SWITCH_OFF_INTERVAL_MS = 300;
  localparam int unsigned BLINK_HZ = 1;
  // Derived cycle counts
  localparam int unsigned ALERT_PULSE_CYC = ALERT_PULSE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SHIP_EXIT_CYC = SHIP_EXIT_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned LONG_PRESS_CYC = LONG_PRESS_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned SWITCH_OFF_CYC = SWITCH_OFF_INTERVAL_MS * (CLK_HZ / 1000);
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  // Counter width, enough for the longest hold
  localparam int unsigned CNT_W = 28;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATE_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  // Control field positions
  localparam int unsigned BOOST_CFG_BIT = 0;
  localparam int unsigned CHARGE_CFG_BIT = 1;
  localparam int unsigned PIN_LIM_EN_BIT = 2;
  localparam int unsigned STATUS_PIN_DISABLE_BIT = 3;
  localparam int unsigned SHIP_ENTER_BIT = 4;
  localparam int unsigned LIMIT_LSB = 8;
  localparam int unsigned LIMIT_W = 6;
  // Control reset value: charging allowed, pin limit enabled, limit code 0x08
  localparam logic [31:0] CTRL_RST = 32'h0000_0806;
  localparam logic [5:0] IRQ_MASK_RST = 6'h00;
  // Interrupt event bit positions
  localparam int unsigned EV_CHARGE = 0;
  localparam int unsigned EV_BOOST = 1;
  localparam int unsigned EV_THERM = 2;
  localparam int unsigned EV_FAULT = 3;
  localparam int unsigned EV_DONE = 4;
  localparam int unsigned EV_WAKE = 5;
  localparam int unsigned EV_W = 6;
  // Control fields as software sees them
  typedef struct packed {
    logic [LIMIT_W-1:0] input_limit_field;
    logic [2:0] spare_bits; // Gap below the limit field, kept at zero
    logic ship_enter;
    logic status_pin_disable;
    logic pin_limit_enable;
    logic charge_config_bit;
    logic boost_config_bit;
  } cpl_ctrl_s;
  // Open-drain pin drive: level and enable (low while driving)
  typedef struct packed {
    logic level;
    logic oe_n;
  } cpl_od_s;
endpackage

// >>> test/cpl_host_model.sv
// Host side of the control pins: drives boost, charge allow and button.
// Assumes commands from the bench; pins move just after a rising edge.
`timescale 1ns/100ps
module cpl_host_model (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic boost_cmd,
  input wire logic allow_n_cmd,
  input wire logic wake_n_cmd,
  // Open-drain alert from the device
  input wire cpl_pkg::cpl_od_s alert,
  // Pins toward the device, never floating
  output logic boost_request = 1'b0,
  output logic charge_allow_n = 1'b1,
  output logic wake_button_n = 1'b1,
  // Alert pulses seen on the pulled-up wire
  output int alerts = 0
);
  logic prev_w = 1'b1; // Wire level at the last edge
  // Pull-up wins unless the device drives low
  wire logic alert_w = alert.oe_n | alert.level;
  // Pins are always driven to a level
  always @(posedge clk) begin
    boost_request <= boost_cmd;
    charge_allow_n <= allow_n_cmd;
    wake_button_n <= wake_n_cmd;
    prev_w <= alert_w;
    if (prev_w && !alert_w) begin
      alerts <= alerts + 1;
    end
  end
endmodule

// >>> test/cpl_top_monitor.sv
// Port checker of the charger pin block, bound into cpl_top.
// Assumes the shortened ship-exit count of the bench.
`timescale 1ns/100ps
module cpl_top_monitor import cpl_pkg::*; #(
  parameter int unsigned SHIP_EXIT_CNT = 40
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic NRST,
  // Watched ports
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic BOOST_REQUEST,
  input wire logic CHARGE_ALLOW_N,
  input wire logic THERM_OUT_OF_RANGE,
  input wire logic WAKE_BUTTON_N,
  input wire logic BOOST_EN,
  input wire logic CHARGE_EN,
  input wire logic BATTERY_SWITCH_ON,
  input wire cpl_od_s ALERT_PIN,
  input wire cpl_od_s STATUS_PIN
);
  logic [11:0] low_r; // Alert low run length
  logic [7:0] btn_r; // Button low run length, saturating
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!NRST);
  // Run lengths; a counter avoids a huge repetition
  always_ff @(posedge REF_CLK or negedge NRST) begin
    if (!NRST) begin
      low_r <= 12'h000;
      btn_r <= 8'h00;
    end else begin
      low_r <= ALERT_PIN.oe_n ? 12'h000 : low_r + 12'h001;
      btn_r <= WAKE_BUTTON_N ? 8'h00 : btn_r + {7'h00, btn_r != 8'hff};
    end
  end
  AST_BUS_OKAY:
    assert property (HREADYOUT && !HRESP) else $error("bus answer not ready okay");
  AST_BOOST_CAUSE:
    assert property (BOOST_EN |-> $past(BOOST_REQUEST, 3)) else $error("boost without request");
  AST_CHARGE_CAUSE:
    assert property (CHARGE_EN |-> !$past(CHARGE_ALLOW_N, 3) && !$past(THERM_OUT_OF_RANGE, 3))
    else $error("charge without allow");
  AST_ALERT_LEN:
    assert property ($rose(ALERT_PIN.oe_n) |-> low_r == ALERT_PULSE_CYC) else $error("alert pulse length");
  AST_ALERT_MAX:
    assert property (low_r <= ALERT_PULSE_CYC) else $error("alert pulse too long");
  AST_OD_LOW:
    assert property ((ALERT_PIN.oe_n || !ALERT_PIN.level) && (STATUS_PIN.oe_n || !STATUS_PIN.level))
    else $error("open drain drives high");
  AST_RST_CYCLE:
    assert property ($fell(BATTERY_SWITCH_ON) && !WAKE_BUTTON_N |-> !BATTERY_SWITCH_ON [*8] ##[1:4] BATTERY_SWITCH_ON)
    else $error("switch off interval");
  AST_WAKE_HOLD:
    assert property ($rose(BATTERY_SWITCH_ON) |-> btn_r >= SHIP_EXIT_CNT) else $error("switch on too early");
  COV_ALERT: cover property ($rose(ALERT_PIN.oe_n));
  COV_SWITCH: cover property ($rose(BATTERY_SWITCH_ON));
  COV_BOOST: cover property ($rose(BOOST_EN));
endmodule

// >>> test/cpl_top_tb.sv
// Self-checking bench of the charger pin block.
// Assumes host model and monitor are compiled before it.
`timescale 1ns/100ps
module cpl_top_tb;
  import cpl_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, boost_c = 1'b0, allow_c = 1'b1, wake_c = 1'b1;
  logic therm = 1'b0, sup = 1'b0, done = 1'b0, fault = 1'b0, rdy, hresp, boost, allow_n, wake_n, boost_en;
  logic chg_en, sw_on, irq;
  logic [1:0] htrans = 2'b00;
  logic [5:0] rpin = 6'h08, lim;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_q;
  cpl_od_s alert, stat;
  int n_errors = 0, n_compared = 0, alerts, n, a0;
  always #50 clk = ~clk;
  cpl_host_model host (.clk(clk), .boost_cmd(boost_c), .allow_n_cmd(allow_c), .wake_n_cmd(wake_c), .alert(alert),
    .boost_request(boost), .charge_allow_n(allow_n), .wake_button_n(wake_n), .alerts(alerts));
  // Short hold counts keep the run brief
  cpl_top #(.SHIP_EXIT_CNT(40), .LONG_PRESS_CNT(100), .SWITCH_OFF_CNT(10), .BLINK_HALF_CNT(8)) dut (
    .REF_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(hresp), .BOOST_REQUEST(boost),
    .CHARGE_ALLOW_N(allow_n), .WAKE_BUTTON_N(wake_n), .THERM_OUT_OF_RANGE(therm), .SUPPLY_PRESENT(sup),
    .CHARGE_DONE(done), .STAGE_FAULT(fault), .RESISTOR_LIMIT_PIN(rpin), .ALERT_PIN(alert), .STATUS_PIN(stat),
    .BOOST_EN(boost_en), .CHARGE_EN(chg_en), .BATTERY_SWITCH_ON(sw_on), .INPUT_LIMIT(lim), .IRQ(irq));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One AHB-Lite single transfer; read data lands in rd_q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd_q = hrdata;
  endtask
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic reset_dut;
    nrst <= 1'b0;
    cyc(8);
    nrst <= 1'b1;
    cyc(1);
  endtask
  task automatic t_regs;
    bus(0, CTRL_OFS, 0);
    chk(rd_q, CTRL_RST);
    bus(1, IRQ_MASK_OFS, 32'h3f);
    bus(0, IRQ_MASK_OFS, 0);
    chk(rd_q, 32'h3f);
    bus(0, 8'h10, 0);
    chk(rd_q, 0);
    $display("regs done");
  endtask
  task automatic t_pins;
    logic [5:0] p[3] = '{6'h05, 6'h20, 6'h05};
    logic [31:0] c[3] = '{32'h0804, 32'h0804, 32'h0800};
    logic [5:0] e[3] = '{6'h05, 6'h08, 6'h08};
    for (int i = 0; i < 8; i++) begin
      bus(1, CTRL_OFS, {30'h0, i[1], i[0]});
      boost_c <= i[2];
      allow_c <= i[1];
      therm <= i[2];
      cyc(6);
      chk(boost_en, i[0] & i[2]);
      chk(chg_en, i[1] & !i[1]);
    end
    for (int i = 0; i < 8; i++) begin
      bus(1, CTRL_OFS, 32'h2);
      allow_c <= i[0];
      therm <= i[1];
      cyc(6);
      chk(chg_en, !i[0] & !i[1]);
    end
    for (int i = 0; i < 3; i++) begin
      rpin <= p[i];
      bus(1, CTRL_OFS, c[i]);
      cyc(2);
      chk(lim, e[i]);
    end
    boost_c <= 1'b0;
    allow_c <= 1'b1;
    therm <= 1'b0;
    $display("pins done");
  endtask
  task automatic t_alert;
    cyc(2600);
    bus(1, IRQ_STAT_OFS, 32'h3f);
    bus(1, IRQ_MASK_OFS, 32'h08);
    chk(irq, 0);
    a0 = alerts;
    fault <= 1'b1;
    n = 0;
    while (alert.oe_n !== 1'b0 && n < 10) begin cyc(1); n++; end
    n = 0;
    while (alert.oe_n === 1'b0 && n < 3000) begin
      if (n == 100) therm <= 1'b1;
      cyc(1);
      n++;
    end
    chk(n, ALERT_PULSE_CYC);
    cyc(2);
    chk(alerts - a0, 1);
    chk(irq, 1);
    bus(0, IRQ_STAT_OFS, 0);
    chk(rd_q & 32'h0c, 32'h0c);
    bus(1, IRQ_STAT_OFS, 32'h08);
    cyc(2);
    chk(irq, 0);
    bus(1, IRQ_MASK_OFS, 32'h0c);
    cyc(2);
    chk(irq, 1);
    therm <= 1'b0;
    $display("alert done");
  endtask
  task automatic t_status;
    logic o;
    for (int k = 0; k < 2; k++) begin
      o = stat.oe_n;
      n = 0;
      while (stat.oe_n === o && n < 20) begin cyc(1); n++; end
    end
    chk(n, 8);
    bus(1, CTRL_OFS, 32'h080e);
    cyc(3);
    chk(stat.oe_n, 1);
    fault <= 1'b0;
    bus(1, CTRL_OFS, CTRL_RST);
    allow_c <= 1'b0;
    cyc(6);
    chk(stat.oe_n, 0);
    done <= 1'b1;
    cyc(3);
    chk(stat.oe_n, 1);
    done <= 1'b0;
    $display("status done");
  endtask
  task automatic press(input int k);
    wake_c <= 1'b0;
    cyc(k);
    wake_c <= 1'b1;
    cyc(4);
  endtask
  task automatic t_wake;
    bus(1, CTRL_OFS, 32'h0816);
    cyc(3);
    chk(sw_on, 0);
    bus(0, STATE_OFS, 0);
    chk(rd_q, 32'h0000_050a);
    press(30);
    press(30);
    chk(sw_on, 0);
    press(50);
    chk(sw_on, 1);
    sup <= 1'b1;
    press(130);
    chk(sw_on, 1);
    sup <= 1'b0;
    cyc(4);
    wake_c <= 1'b0;
    n = 0;
    while (sw_on === 1'b1 && n < 200) begin cyc(1); n++; end
    chk(n >= 100 && n <= 106, 1);
    n = 0;
    while (sw_on !== 1'b1 && n < 50) begin cyc(1); n++; end
    chk(n, 10);
    wake_c <= 1'b1;
    $display("wake done");
  endtask
  initial begin
    reset_dut();
    t_regs();
    t_pins();
    t_alert();
    t_status();
    reset_dut();
    t_regs();
    t_wake();
    tally_and_finish();
  end
  // Whole run needs about 5800 cycles
  initial begin
    cyc(30000);
    n_errors++;
    tally_and_finish();
  end
endmodule
bind cpl_top cpl_top_monitor #(.SHIP_EXIT_CNT(SHIP_EXIT_CNT)) u_mon (.*);
